// file: pkg/clk_cfg_pkg.sv
`default_nettype none
package clk_cfg_pkg;
  localparam int          OUT_CNT       = 8;
  localparam int          CODE_W        = 7;
  localparam int          RATIO_W       = 8;
  localparam int          IDX_W         = 6;
  localparam int          WB_AW         = 8;
  localparam int          WB_DW         = 32;
  // Word indices; byte address is four times the index
  localparam logic [5:0]  OUTCFG_BASE_IDX = 6'h01;
  localparam logic [5:0]  FBCFG_IDX       = 6'h0b;
  localparam logic [5:0]  STATUS_IDX      = 6'h0d;
  localparam logic [5:0]  NV_BASE_IDX     = 6'h10;
  localparam logic [5:0]  NV_FB_IDX       = 6'h18;
  // Field positions
  localparam int          OUT_CODE_LSB  = 13;
  localparam int          FB_CODE_LSB   = 5;
  localparam int          PHASE_LSB     = 0;
  localparam int          PHASE_W       = 7;
  localparam int          TYPE_LSB      = 20;
  localparam int          TYPE_W        = 2;
  localparam int          ALT_TYPE_LSB  = 22;
  localparam int          AUX_SEL_BIT   = 0;
  // Status word bits
  localparam int          ST_MODE_BIT   = 0;
  localparam int          ST_SWAP_BIT   = 1;
  localparam int          ST_TYPE_BIT   = 2;
  localparam int          ST_SPARE_BIT  = 3;
  localparam int          ST_AUX_BIT    = 4;
  localparam int          ST_FBBAD_BIT  = 5;
  localparam int          ST_BAD_LSB    = 8;
  // Reset values: every divider passes the clock undivided
  localparam logic [31:0] OUTCFG_RESET  = 32'h0004_0000;
  localparam logic [31:0] FBCFG_RESET   = 32'h0000_0400;
  // Ratio code classes on bits 6:5
  localparam logic [1:0]  CLS_PRODUCT   = 2'h0;
  localparam logic [1:0]  CLS_BYPASS    = 2'h1;
  localparam logic [1:0]  CLS_SMALL     = 2'h2;
  localparam logic [7:0]  RATIO_ONE     = 8'h01;
  localparam logic [7:0]  RATIO_SMALL_BASE = 8'h02;
  localparam logic [7:0]  RATIO_BAD     = 8'h00;
  // Codes 0..31 of the product class that carry the shifted phase
  localparam logic [31:0] PRIMED_MASK   = 32'h3017_3111;
  localparam logic [1:0]  SYNC_SETTLE   = 2'h2;
  typedef enum logic [2:0] {
    ST_SETTLE = 3'b001,
    ST_LOAD   = 3'b010,
    ST_RUN    = 3'b100
  } loader_state_t;
endpackage : clk_cfg_pkg
`default_nettype wire

// file: hw/ratio_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module ratio_decoder
  import clk_cfg_pkg::*;
(
  // Ratio code
  input  wire logic [clk_cfg_pkg::CODE_W-1:0]  code,
  // Decoded ratio
  output logic      [clk_cfg_pkg::RATIO_W-1:0] ratio,
  output logic                                 primed,
  output logic                                 bad
);
  logic [2:0] k;
  logic [1:0] m;
  logic [7:0] prod;

  always_comb begin
    k      = code[4:2];
    m      = code[1:0];
    prod   = 8'((({5'h0, k} + 8'h01) * ({6'h0, m} + 8'h02)) << 1);
    ratio  = RATIO_BAD;
    primed = 1'b0;
    bad    = 1'b0;
    case (code[6:5])
      CLS_BYPASS: begin
        if (code[4:0] == 5'h00) begin
          ratio = RATIO_ONE;
        end else begin
          bad = 1'b1;
        end
      end
      CLS_SMALL: begin
        if (k == 3'h0) begin
          ratio = RATIO_SMALL_BASE + {6'h0, m};
        end else begin
          bad = 1'b1;
        end
      end
      CLS_PRODUCT: begin
        ratio  = prod;
        primed = PRIMED_MASK[code[4:0]];
      end
      default: begin
        bad = 1'b1;  // Both class bits set: no ratio
      end
    endcase
  end
endmodule : ratio_decoder
`default_nettype wire

// file: hw/output_divider_and_strap_config.sv
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module output_divider_and_strap_config
  import clk_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                                        core_clk,
  input  wire logic                                        reset_n,
  // Wishbone slave
  input  wire logic                                        wb_cyc_i,
  input  wire logic                                        wb_stb_i,
  input  wire logic                                        wb_we_i,
  input  wire logic [clk_cfg_pkg::WB_AW-1:0]               wb_adr_i,
  input  wire logic [3:0]                                  wb_sel_i,
  input  wire logic [clk_cfg_pkg::WB_DW-1:0]               wb_dat_i,
  output logic      [clk_cfg_pkg::WB_DW-1:0]               wb_dat_o,
  output logic                                             wb_ack_o,
  // Pins
  input  wire logic                                        configSourceSel,
  input  wire logic                                        powerDown,
  input  wire logic                                        divider_swap_select,
  input  wire logic                                        output_type_select,
  input  wire logic                                        spare_strap_select,
  input  wire logic                                        auxMuxSelect,
  // Divider chains
  output logic      [clk_cfg_pkg::OUT_CNT*clk_cfg_pkg::RATIO_W-1:0] outRatio,
  output logic      [clk_cfg_pkg::OUT_CNT-1:0]             outPrimed,
  output logic      [clk_cfg_pkg::OUT_CNT*clk_cfg_pkg::TYPE_W-1:0]  outType,
  output logic      [clk_cfg_pkg::RATIO_W-1:0]             fbRatio,
  output logic                                             fbPrimed,
  output logic                                             auxOutSel,
  output logic                                             pin_strap_config_mode
);
  import clk_cfg_pkg::*;

  // Pin synchronisers: stage one feeds stage two only
  logic [5:0] pinMeta;
  logic [5:0] pinSync;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta <= 6'h00;
      pinSync <= 6'h00;
    end else begin
      pinMeta <= {configSourceSel, powerDown, divider_swap_select,
                  output_type_select, spare_strap_select, auxMuxSelect};
      pinSync <= pinMeta;
    end
  end
  logic modeSelS, pdS, swapS, typeS, spareS, auxS;
  assign {modeSelS, pdS, swapS, typeS, spareS, auxS} = pinSync;

  // Loader sequencer
  loader_state_t state;
  loader_state_t next_state;
  logic [1:0]    settleCnt;
  logic [1:0]    next_settleCnt;
  logic          loadNow;

  always_comb begin
    next_state     = state;
    next_settleCnt = settleCnt;
    case (state)
      ST_SETTLE: begin
        next_settleCnt = settleCnt + 2'h1;
        if (settleCnt == SYNC_SETTLE) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (!pdS) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pdS) begin
          next_state = ST_LOAD;
        end
      end
      default: begin
        next_state = ST_SETTLE;
      end
    endcase
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= ST_SETTLE;
      settleCnt <= 2'h0;
    end else begin
      state     <= next_state;
      settleCnt <= next_settleCnt;
    end
  end
  assign loadNow = (state == ST_LOAD);

  // Latched straps
  logic strapMode, swapL, typeL, spareL, auxL;
  logic next_strapMode, next_swapL, next_typeL, next_spareL, next_auxL;
  always_comb begin
    next_strapMode = strapMode;
    next_swapL     = swapL;
    next_typeL     = typeL;
    next_spareL    = spareL;
    next_auxL      = auxL;
    if (loadNow) begin  // Pin changes ignored elsewhere
      next_strapMode = !modeSelS;
      next_swapL     = swapS;
      next_typeL     = typeS;
      next_spareL    = spareS;  // Reported only, expected low
      next_auxL      = auxS;
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strapMode <= 1'b0;
      swapL     <= 1'b0;
      typeL     <= 1'b0;
      spareL    <= 1'b0;
      auxL      <= 1'b0;
    end else begin
      strapMode <= next_strapMode;
      swapL     <= next_swapL;
      typeL     <= next_typeL;
      spareL    <= next_spareL;
      auxL      <= next_auxL;
    end
  end

  // Bus decode
  logic [IDX_W-1:0] adrIdx;
  logic             busWrite;
  logic             strapLoad;
  assign adrIdx    = wb_adr_i[WB_AW-1:2];
  assign busWrite  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign strapLoad = loadNow && !modeSelS;

  function automatic logic [31:0] mergeSel(input logic [31:0] old, input logic [31:0] din,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = din[b*8 +: 8];
      end
    end
    return r;
  endfunction : mergeSel

  // Working and stored configuration words
  logic [31:0] outCfg [OUT_CNT];
  logic [31:0] next_outCfg [OUT_CNT];
  logic [31:0] nvImg [OUT_CNT];
  logic [31:0] next_nvImg [OUT_CNT];
  logic [31:0] fbCfg;
  logic [31:0] next_fbCfg;
  logic [31:0] nvFb;
  logic [31:0] next_nvFb;

  always_comb begin
    logic [31:0] src;
    logic [31:0] mate;
    src  = 32'h0;
    mate = 32'h0;
    for (int i = 0; i < OUT_CNT; i++) begin
      next_outCfg[i] = outCfg[i];
      next_nvImg[i]  = nvImg[i];
      src            = nvImg[i];
      mate           = nvImg[i ^ 1];
      if (busWrite && adrIdx == NV_BASE_IDX + IDX_W'(i)) begin
        next_nvImg[i] = mergeSel(nvImg[i], wb_dat_i, wb_sel_i);
      end
      if (strapLoad) begin  // Straps pick the copied image
        next_outCfg[i] = src;
        if (swapS) begin
          next_outCfg[i][OUT_CODE_LSB +: CODE_W] = mate[OUT_CODE_LSB +: CODE_W];
          next_outCfg[i][PHASE_LSB +: PHASE_W]   = mate[PHASE_LSB +: PHASE_W];
        end
        if (typeS) begin
          next_outCfg[i][TYPE_LSB +: TYPE_W] = src[ALT_TYPE_LSB +: TYPE_W];
        end
      end else if (busWrite && !strapMode && adrIdx == OUTCFG_BASE_IDX + IDX_W'(i)) begin
        next_outCfg[i] = mergeSel(outCfg[i], wb_dat_i, wb_sel_i);
      end
    end
    next_nvFb  = nvFb;
    next_fbCfg = fbCfg;
    if (busWrite && adrIdx == NV_FB_IDX) begin
      next_nvFb = mergeSel(nvFb, wb_dat_i, wb_sel_i);
    end
    if (strapLoad) begin
      next_fbCfg = nvFb;
    end else if (busWrite && !strapMode && adrIdx == FBCFG_IDX) begin
      next_fbCfg = mergeSel(fbCfg, wb_dat_i, wb_sel_i);
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < OUT_CNT; i++) begin
        outCfg[i] <= OUTCFG_RESET;
        nvImg[i]  <= OUTCFG_RESET;
      end
      fbCfg <= FBCFG_RESET;
      nvFb  <= FBCFG_RESET;
    end else begin
      for (int i = 0; i < OUT_CNT; i++) begin
        outCfg[i] <= next_outCfg[i];
        nvImg[i]  <= next_nvImg[i];
      end
      fbCfg <= next_fbCfg;
      nvFb  <= next_nvFb;
    end
  end

  // Ratio decoders
  logic [RATIO_W-1:0] decRatio [OUT_CNT+1];
  logic [OUT_CNT:0]   decPrimed;
  logic [OUT_CNT:0]   decBad;
  logic [CODE_W-1:0]  decCode [OUT_CNT+1];
  genvar g;
  generate
    for (g = 0; g <= OUT_CNT; g++) begin : g_dec
      if (g < OUT_CNT) begin : g_out
        assign decCode[g] = outCfg[g][OUT_CODE_LSB +: CODE_W];
      end else begin : g_fb
        assign decCode[g] = fbCfg[FB_CODE_LSB +: CODE_W];
      end
      ratio_decoder ratio_decoder_i (
        .code   (decCode[g]),
        .ratio  (decRatio[g]),
        .primed (decPrimed[g]),
        .bad    (decBad[g])
      );
    end
  endgenerate

  // Registered outputs toward the divider chains
  logic [OUT_CNT*RATIO_W-1:0] next_outRatio;
  logic [OUT_CNT*TYPE_W-1:0]  next_outType;
  logic                       next_auxOutSel;
  logic [OUT_CNT:0]           badReg;
  always_comb begin
    for (int i = 0; i < OUT_CNT; i++) begin
      next_outRatio[i*RATIO_W +: RATIO_W] = decRatio[i];
      next_outType[i*TYPE_W +: TYPE_W]    = outCfg[i][TYPE_LSB +: TYPE_W];
    end
    next_auxOutSel = strapMode ? auxL : fbCfg[AUX_SEL_BIT];
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      outRatio              <= '0;
      outPrimed             <= '0;
      outType               <= '0;
      fbRatio               <= '0;
      fbPrimed              <= 1'b0;
      auxOutSel             <= 1'b0;
      pin_strap_config_mode <= 1'b0;
      badReg                <= '0;
    end else begin
      outRatio              <= next_outRatio;
      outPrimed             <= decPrimed[OUT_CNT-1:0];
      outType               <= next_outType;
      fbRatio               <= decRatio[OUT_CNT];
      fbPrimed              <= decPrimed[OUT_CNT];
      auxOutSel             <= next_auxOutSel;
      pin_strap_config_mode <= strapMode;
      badReg                <= decBad;
    end
  end

  // Bus answer: ack one cycle after request, unmapped reads zero
  logic [31:0] rdMux;
  logic [31:0] next_rdata;
  logic        next_ack;
  always_comb begin
    rdMux = 32'h0;
    for (int i = 0; i < OUT_CNT; i++) begin
      if (adrIdx == OUTCFG_BASE_IDX + IDX_W'(i)) begin
        rdMux = outCfg[i];
      end
      if (adrIdx == NV_BASE_IDX + IDX_W'(i)) begin
        rdMux = nvImg[i];
      end
    end
    if (adrIdx == FBCFG_IDX) begin
      rdMux = fbCfg;
    end
    if (adrIdx == NV_FB_IDX) begin
      rdMux = nvFb;
    end
    if (adrIdx == STATUS_IDX) begin
      rdMux[ST_MODE_BIT]                 = strapMode;
      rdMux[ST_SWAP_BIT]                 = swapL;
      rdMux[ST_TYPE_BIT]                 = typeL;
      rdMux[ST_SPARE_BIT]                = spareL;
      rdMux[ST_AUX_BIT]                  = auxL;
      rdMux[ST_FBBAD_BIT]                = badReg[OUT_CNT];
      rdMux[ST_BAD_LSB +: OUT_CNT]       = badReg[OUT_CNT-1:0];
    end
    next_ack   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_rdata = next_ack ? rdMux : wb_dat_o;
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdata;
    end
  end

  // Checks
  bus_ack_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("Bus request not acknowledged next cycle");

  strap_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state != ST_LOAD) |=> $stable(swapL) && $stable(typeL) && $stable(auxL) && $stable(strapMode))
    else $error("Strap latch changed outside a load");

  strap_entry_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state == ST_LOAD) |=> strapMode == !$past(modeSelS) ##1 pin_strap_config_mode == $past(strapMode))
    else $error("Strap mode does not follow select pin");

  pair_swap_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    strapLoad && swapS |=> outCfg[0][OUT_CODE_LSB +: CODE_W] == $past(nvImg[1][OUT_CODE_LSB +: CODE_W])
      && outCfg[1][PHASE_LSB +: PHASE_W] == $past(nvImg[0][PHASE_LSB +: PHASE_W]))
    else $error("Pair swap did not exchange ratio and phase");

  alt_type_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    strapLoad |=> outCfg[3][TYPE_LSB +: TYPE_W] == ($past(typeS) ? $past(nvImg[3][ALT_TYPE_LSB +: TYPE_W])
      : $past(nvImg[3][TYPE_LSB +: TYPE_W])))
    else $error("Output type not taken from selected image");

  aux_mux_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    strapMode && $stable(strapMode) |=> auxOutSel == $past(auxL))
    else $error("Aux select does not follow latched strap");

  bypass_ratio_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    outCfg[2][OUT_CODE_LSB +: CODE_W] == 7'h20 |=> outRatio[2*RATIO_W +: RATIO_W] == 8'h01)
    else $error("Bypass code did not give ratio one");

  product_ratio_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    fbCfg[FB_CODE_LSB +: CODE_W] == 7'h1f |=> fbRatio == 8'h50 && !fbPrimed)
    else $error("Feedback code 31 did not divide by 80");

  bad_code_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    outCfg[0][OUT_CODE_LSB + 5 +: 2] == 2'h3 |=> outRatio[0 +: RATIO_W] == 8'h00 && badReg[0])
    else $error("Unsupported code not held at zero ratio");

  strap_lock_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    strapMode && !loadNow |=> $stable(fbCfg))
    else $error("Working register changed by bus in strap mode");
endmodule : output_divider_and_strap_config
`default_nettype wire

// file: tb/strap_board.sv
`timescale 1ns/100ps
`default_nettype none
module strap_board (
  // Board wishes
  input  wire logic strapMode,
  input  wire logic swapWanted,
  input  wire logic typeWanted,
  input  wire logic auxWanted,
  input  wire logic pdWanted,
  // Pins
  output logic      configSourceSel,
  output logic      powerDown,
  output logic      divider_swap_select,
  output logic      output_type_select,
  output logic      spare_strap_select,
  output logic      auxMuxSelect
);
  assign configSourceSel     = ~strapMode;
  // Outside strap mode this pin is an idle serial line
  assign spare_strap_select  = strapMode ? 1'b0 : 1'b1;
  assign divider_swap_select = swapWanted;
  assign output_type_select  = typeWanted;
  assign auxMuxSelect        = auxWanted;
  assign powerDown           = pdWanted;
endmodule : strap_board
`default_nettype wire

// file: tb/output_divider_and_strap_config_test.sv
`timescale 1ns/100ps
`default_nettype none
module output_divider_and_strap_config_test;
  import clk_cfg_pkg::*;
  logic                 core_clk = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 wb_cyc_i = 1'b0;
  logic                 wb_stb_i = 1'b0;
  logic                 wb_we_i = 1'b0;
  logic [WB_AW-1:0]     wb_adr_i = '0;
  logic [3:0]           wb_sel_i = 4'h0;
  logic [WB_DW-1:0]     wb_dat_i = '0;
  logic [WB_DW-1:0]     wb_dat_o;
  logic                 wb_ack_o;
  logic                 strapMode = 1'b0;
  logic                 swapWanted = 1'b0;
  logic                 typeWanted = 1'b0;
  logic                 auxWanted = 1'b0;
  logic                 pdWanted = 1'b0;
  logic                 configSourceSel, powerDown, swapPin, typePin, sparePin, auxPin;
  logic [OUT_CNT*RATIO_W-1:0] outRatio;
  logic [OUT_CNT-1:0]   outPrimed;
  logic [OUT_CNT*TYPE_W-1:0] outType;
  logic [RATIO_W-1:0]   fbRatio;
  logic                 fbPrimed, auxOutSel, pin_strap_config_mode;
  logic [31:0]          rd;
  int                   n_mismatch = 0;
  int                   tests_run = 0;

  output_divider_and_strap_config output_divider_and_strap_config_i (
    .core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .configSourceSel(configSourceSel),
    .powerDown(powerDown), .divider_swap_select(swapPin), .output_type_select(typePin),
    .spare_strap_select(sparePin), .auxMuxSelect(auxPin), .outRatio(outRatio),
    .outPrimed(outPrimed), .outType(outType), .fbRatio(fbRatio), .fbPrimed(fbPrimed),
    .auxOutSel(auxOutSel), .pin_strap_config_mode(pin_strap_config_mode));

  strap_board strap_board_i (
    .strapMode(strapMode), .swapWanted(swapWanted), .typeWanted(typeWanted),
    .auxWanted(auxWanted), .pdWanted(pdWanted), .configSourceSel(configSourceSel),
    .powerDown(powerDown), .divider_swap_select(swapPin), .output_type_select(typePin),
    .spare_strap_select(sparePin), .auxMuxSelect(auxPin));

  always #50 core_clk = ~core_clk;

  task end_sim;
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : waitc

  // Classic single cycle, held until ack is sampled high
  task automatic wbXfer(input logic we, input logic [5:0] idx, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk("wbAckWait", 32'(n), 32'h2);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wbXfer

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] q;
    wbXfer(1'b1, idx, d, q);
  endtask : wr

  function automatic logic [7:0] expRatio(input logic [6:0] c);
    case (c[6:5])
      2'b01: return (c[4:0] == 5'h00) ? 8'h01 : 8'h00;
      2'b10: return (c[4:2] == 3'h0) ? 8'(2 + c[1:0]) : 8'h00;
      2'b00: return 8'(2 * (c[4:2] + 1) * (c[1:0] + 2));
      default: return 8'h00;
    endcase
  endfunction : expRatio

  function automatic logic expPrimed(input logic [6:0] c);
    return (c[6:5] == 2'b00) && (c[4:0] inside {0, 4, 8, 12, 13, 16, 17, 18, 20, 28, 29});
  endfunction : expPrimed

  // Stored image: alt type, type, code, phase
  function automatic logic [31:0] img(input int i);
    return {8'h00, 2'(~i), 2'(i), 7'(i + 9), 6'h00, 7'(i + 1)};
  endfunction : img

  task automatic strapLoad(input logic mode, input logic s, input logic t, input logic a);
    @(posedge core_clk);
    strapMode  <= mode;
    swapWanted <= s;
    typeWanted <= t;
    auxWanted  <= a;
    waitc(3);
    pdWanted <= 1'b1;
    waitc(4);
    pdWanted <= 1'b0;
    waitc(8);
  endtask : strapLoad

  task automatic testReset;
    chk("outRatio", outRatio[31:0], {4{RATIO_ONE}});
    chk("fbRatio", {24'h0, fbRatio}, 32'h1);
    wbXfer(1'b0, OUTCFG_BASE_IDX, 32'h0, rd);
    chk("outCfgReset", rd, OUTCFG_RESET);
    wbXfer(1'b0, FBCFG_IDX, 32'h0, rd);
    chk("fbCfgReset", rd, FBCFG_RESET);
    wr(6'h3f, 32'h1234_5678);
    wbXfer(1'b0, 6'h3f, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
  endtask : testReset

  task automatic testDecode;
    for (int c = 0; c < 128; c++) begin
      wr(OUTCFG_BASE_IDX, 32'(c) << OUT_CODE_LSB);
      wr(FBCFG_IDX, 32'(c) << FB_CODE_LSB);
      waitc(4);
      chk("outRatio0", {24'h0, outRatio[7:0]}, {24'h0, expRatio(7'(c))});
      chk("outPrimed0", {31'h0, outPrimed[0]}, {31'h0, expPrimed(7'(c))});
      chk("fbRatio", {24'h0, fbRatio}, {24'h0, expRatio(7'(c))});
      chk("fbPrimed", {31'h0, fbPrimed}, {31'h0, expPrimed(7'(c))});
      wbXfer(1'b0, STATUS_IDX, 32'h0, rd);
      chk("badOut0", {31'h0, rd[ST_BAD_LSB]}, {31'h0, expRatio(7'(c)) == 8'h00});
      chk("badFb", {31'h0, rd[ST_FBBAD_BIT]}, {31'h0, expRatio(7'(c)) == 8'h00});
    end
  endtask : testDecode

  task automatic testFields;
    for (int i = 0; i < 8; i++) wr(6'(OUTCFG_BASE_IDX + i), 32'(i + 9) << OUT_CODE_LSB);
    waitc(4);
    for (int i = 0; i < 8; i++) chk("outRatioN", {24'h0, outRatio[8*i +: 8]}, {24'h0, expRatio(7'(i + 9))});
  endtask : testFields

  task automatic testStrap;
    int src;
    for (int i = 0; i < 8; i++) wr(6'(NV_BASE_IDX + i), img(i));
    wr(NV_FB_IDX, 32'h43 << FB_CODE_LSB);
    for (int m = 0; m < 4; m++) begin
      strapLoad(1'b1, m[0], m[1], m[1]);
      chk("strapMode", {31'h0, pin_strap_config_mode}, 32'h1);
      chk("auxOutSel", {31'h0, auxOutSel}, {31'h0, m[1]});
      chk("fbImage", {24'h0, fbRatio}, 32'h5);
      for (int i = 0; i < 8; i++) begin
        src = m[0] ? (i ^ 1) : i;
        chk("swapRatio", {24'h0, outRatio[8*i +: 8]}, {24'h0, expRatio(7'(src + 9))});
        chk("altType", {30'h0, outType[2*i +: 2]}, {30'h0, m[1] ? 2'(~i) : 2'(i)});
        wbXfer(1'b0, 6'(OUTCFG_BASE_IDX + i), 32'h0, rd);
        chk("swapPhase", {25'h0, rd[6:0]}, 32'(src + 1));
        chk("swapCode", {25'h0, rd[19:13]}, 32'(src + 9));
      end
    end
  endtask : testStrap

  task automatic testHold;
    @(posedge core_clk);
    swapWanted <= 1'b0;
    typeWanted <= 1'b0;
    auxWanted  <= 1'b0;
    waitc(10);
    chk("holdAux", {31'h0, auxOutSel}, 32'h1);
    chk("holdRatio", {24'h0, outRatio[7:0]}, {24'h0, expRatio(7'd10)});
    wr(OUTCFG_BASE_IDX, OUTCFG_RESET);
    wr(STATUS_IDX, 32'h0);
    waitc(4);
    chk("strapWrIgnored", {24'h0, outRatio[7:0]}, {24'h0, expRatio(7'd10)});
    wbXfer(1'b0, STATUS_IDX, 32'h0, rd);
    chk("statusMode", {31'h0, rd[ST_MODE_BIT]}, 32'h1);
    chk("statusSpare", {31'h0, rd[ST_SPARE_BIT]}, 32'h0);
    chk("statusSwap", {31'h0, rd[ST_SWAP_BIT]}, 32'h1);
  endtask : testHold

  task automatic testExit;
    strapLoad(1'b0, 1'b0, 1'b0, 1'b0);
    chk("exitMode", {31'h0, pin_strap_config_mode}, 32'h0);
    wr(FBCFG_IDX, FBCFG_RESET | 32'h1);
    wr(OUTCFG_BASE_IDX, 32'h41 << OUT_CODE_LSB);
    waitc(4);
    chk("regAux", {31'h0, auxOutSel}, 32'h1);
    chk("regRatio", {24'h0, outRatio[7:0]}, 32'h3);
  endtask : testExit

  initial begin
    waitc(2);
    reset_n <= 1'b1;
    waitc(8);
    testReset();
    testDecode();
    testFields();
    testStrap();
    testHold();
    testExit();
    end_sim();
  end

  initial begin
    waitc(20000);
    n_mismatch++;
    end_sim();
  end
endmodule : output_divider_and_strap_config_test
`default_nettype wire
